// >>> peq_perf_event_qualifier.sv
// peq_perf_event_qualifier: qualifier filters and one event counter
// observed request, axi and trace-drop inputs are synchronous to i_clk
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - source bits 29..22 enable requests from input ports 7..0
// - bits 21..18: coherent other, read-discard, accel uncached, uncached
// - bits 17..10 enable burst length codes 7..0
// - bits 9..2 enable sizes 128..1 bytes; bit 1 writes, bit 0 reads
// - axi channel field 6:4 picks ar, aw, w, r or b
// - bit 3 counts ready-high cycles, bit 2 ready-low cycles
// - bit 1 counts valid-high cycles, bit 0 valid-low cycles
// - bit 7 counts response drops on pipe, multi and uncached ports
// - bit 6 counts request drops on the two plain pipe ports only
// - bits 5,4 pipe one multi/plain; bits 3,2 pipe zero multi/plain
// - bit 1 perf tracing port drops; bit 0 uncached response drops
// - event 3 counts qualified memory interface requests
// - event 7 memory axi bus, events 8..15 io unit buses 0..7
// - event 17 counts qualified trace overflow drops
module peq_perf_event_qualifier
  import peq_pkg::*;
(
  input wire logic i_clk,                         // core clock
  input wire logic i_rst_n,                       // async reset, low
  input wire logic [ADDR_W-1:0] i_addr,           // register address
  input wire logic [31:0] i_wdata,                // register write data
  input wire logic i_wr,                          // write strobe
  input wire logic i_rd,                          // read strobe
  output logic [31:0] o_rdata,                    // read data, next cycle
  input wire logic i_mem_vld,                     // memory request issued
  input wire logic [2:0] i_mem_port,              // source input port
  input wire logic [1:0] i_mem_cca,               // cacheability code
  input wire logic [2:0] i_mem_len,               // burst length code
  input wire logic [2:0] i_mem_size,              // log2 bytes/transfer
  input wire logic i_mem_wr,                      // 1 write, 0 read
  input wire logic [NUM_BUS*NUM_CHAN-1:0] i_axi_valid, // bus*5+chan
  input wire logic [NUM_BUS*NUM_CHAN-1:0] i_axi_ready, // bus*5+chan
  input wire logic [NUM_TPORT-1:0] i_drop_rsp,    // response drop pulses
  input wire logic [NUM_TPORT-1:0] i_drop_req,    // request drop pulses
  output logic [31:0] o_count,                    // counter value
  output logic [2:0] o_count_inc                  // last increment
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one qualifier bit picked by field base and attribute code
  function automatic logic qbit(input logic [31:0] q, input int lsb,
                                input logic [2:0] code);
    logic [4:0] pos;
    pos = 5'(lsb) + {2'h0, code};
    qbit = q[pos];
  endfunction : qbit

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [4:0] evsel_ff;
  logic [31:0] qual_ff;
  logic en_ff;
  logic [31:0] count_ff;
  logic [31:0] rdata_ff;
  logic [2:0] inc_ff;
  logic [4:0] nxt_evsel;
  logic [31:0] nxt_qual;
  logic nxt_en;
  logic [31:0] nxt_count;
  logic [31:0] nxt_rdata;

  // register decode
  wire logic wr_evsel = i_wr && (i_addr == OFS_EVSEL);
  wire logic wr_qual = i_wr && (i_addr == OFS_QUAL);
  wire logic wr_ctrl = i_wr && (i_addr == OFS_CTRL);
  wire logic wr_count = i_wr && (i_addr == OFS_COUNT);
  wire logic clr_cnt = wr_ctrl && i_wdata[CTRL_CLR];

  // ---------------------------------------------------------------
  // event selection
  // ---------------------------------------------------------------
  wire logic sel_mem = (evsel_ff == EV_MEM_REQ);
  wire logic sel_axi_mem = (evsel_ff == EV_AXI_MEM);
  wire logic sel_axi_io = (evsel_ff >= EV_AXI_IO_FIRST) &&
                          (evsel_ff <= EV_AXI_IO_LAST);
  wire logic sel_axi = sel_axi_mem || sel_axi_io;
  wire logic sel_trace = (evsel_ff == EV_TRACE_DROP);
  // memory bus is index 0, io unit n is index n+1
  wire logic [3:0] bus_idx = sel_axi_io ? (evsel_ff[3:0] -
                             EV_AXI_IO_FIRST[3:0] + 4'h1) : 4'h0;

  // ---------------------------------------------------------------
  // memory request qualification; groups are anded
  // ---------------------------------------------------------------
  wire logic mq_src = qbit(qual_ff, SRC_LSB, i_mem_port);
  wire logic mq_cca = qbit(qual_ff, CCA_LSB, {1'b0, i_mem_cca});
  wire logic mq_len = qbit(qual_ff, LEN_LSB, i_mem_len);
  wire logic mq_size = qbit(qual_ff, SIZE_LSB, i_mem_size);
  wire logic mq_dir = i_mem_wr ? qual_ff[DIR_WR] : qual_ff[DIR_RD];
  wire logic mem_hit = sel_mem && i_mem_vld && mq_src && mq_cca &&
                       mq_len && mq_size && mq_dir;

  // ---------------------------------------------------------------
  // axi utilisation; channel codes above b never count
  // ---------------------------------------------------------------
  wire logic [2:0] chan = qual_ff[CHAN_MSB:CHAN_LSB];
  wire logic chan_ok = (chan <= CHAN_LAST);
  wire logic [5:0] axi_idx = 6'(bus_idx) * 6'(NUM_CHAN) + 6'(chan);
  wire logic ch_vld = chan_ok ? i_axi_valid[axi_idx] : 1'b0;
  wire logic ch_rdy = chan_ok ? i_axi_ready[axi_idx] : 1'b0;
  wire logic aq_rdy = ch_rdy ? qual_ff[AXI_RDY] : qual_ff[AXI_NRDY];
  wire logic aq_vld = ch_vld ? qual_ff[AXI_VLD] : qual_ff[AXI_NVLD];
  wire logic axi_hit = sel_axi && chan_ok && aq_rdy && aq_vld;

  // ---------------------------------------------------------------
  // trace drop qualification, one slice per trace port
  // ---------------------------------------------------------------
  logic [NUM_TPORT-1:0] tr_hit;
  // ports that carry neither trace type; the type bits do not apply there
  wire logic [NUM_TPORT-1:0] untyped_ports = ~(TR_RSP_PORTS | TR_REQ_PORTS);
  genvar gp;
  generate
    for (gp = 0; gp < NUM_TPORT; gp++) begin : g_tport
      // response drops only on ports that carry responses
      wire logic rsp_ok = i_drop_rsp[gp] && qual_ff[TR_RSP] &&
                          TR_RSP_PORTS[gp];
      // request drops only on the plain pipe ports
      wire logic req_ok = i_drop_req[gp] && qual_ff[TR_REQ] &&
                          TR_REQ_PORTS[gp];
      // the perf tracing port has no trace type: any drop there counts
      wire logic any_ok = (i_drop_rsp[gp] || i_drop_req[gp]) &&
                          untyped_ports[gp];
      // port enable bit sits at the port's own index
      assign tr_hit[gp] = sel_trace && qual_ff[gp] &&
                          (rsp_ok || req_ok || any_ok);
    end
  endgenerate

  // count of qualifying drops this cycle; several ports may drop at once
  logic [2:0] tr_cnt;
  always_comb begin
    tr_cnt = 3'h0;
    for (int i = 0; i < NUM_TPORT; i++) begin
      tr_cnt = tr_cnt + {2'h0, tr_hit[i]};
    end
  end

  // only one event class is selected, so the terms never overlap;
  // bits 31:30 and the unused upper bits of other events are ignored
  wire logic [2:0] inc = tr_cnt + {2'h0, mem_hit} +
                         {2'h0, axi_hit};

  // increment as applied: a clear or count write in the same cycle wins,
  // the event is lost, and the monitor output must not claim it
  wire logic [2:0] inc_apply = (en_ff && !clr_cnt && !wr_count) ? inc :
                               3'h0;

  // ---------------------------------------------------------------
  // next-state: software writes, then counting
  // ---------------------------------------------------------------
  // a clear and an event in one cycle: the clear wins, the event is
  // dropped, because software asked for a fresh start at that moment
  always_comb begin
    nxt_evsel = wr_evsel ? i_wdata[4:0] : evsel_ff;
    nxt_qual = wr_qual ? i_wdata : qual_ff;
    nxt_en = wr_ctrl ? i_wdata[CTRL_EN] : en_ff;
    if (clr_cnt) begin
      nxt_count = 32'h00000000;
    end else if (wr_count) begin
      nxt_count = i_wdata;
    end else if (en_ff) begin
      nxt_count = count_ff + {29'h0, inc};
    end else begin
      nxt_count = count_ff;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (i_rd) begin
      case (i_addr)
        OFS_EVSEL: nxt_rdata = {27'h0, evsel_ff};
        OFS_QUAL: nxt_rdata = qual_ff;
        OFS_CTRL: nxt_rdata = {31'h0, en_ff};
        OFS_COUNT: nxt_rdata = count_ff;
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // flip-flops
  // ---------------------------------------------------------------
  // control registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evsel_ff <= EVSEL_RST;
      qual_ff <= QUAL_RST;
      en_ff <= 1'b0;
    end else begin
      evsel_ff <= nxt_evsel;
      qual_ff <= nxt_qual;
      en_ff <= nxt_en;
    end
  end

  // counter and read data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_ff <= 32'h00000000;
      rdata_ff <= 32'h00000000;
      inc_ff <= 3'h0;
    end else begin
      count_ff <= nxt_count;
      rdata_ff <= nxt_rdata;
      inc_ff <= inc_apply;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_count = count_ff;
  assign o_count_inc = inc_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  wire logic quiet = !i_wr;  // no software write in this cycle

  AST_SRC_GATE: assert property (
    sel_mem && !qual_ff[SRC_LSB + 32'(i_mem_port)] |-> !mem_hit)
    else $error("request from disabled port was counted");

  AST_CCA_GATE: assert property (
    sel_mem && !qual_ff[CCA_LSB + 32'(i_mem_cca)] |-> inc == 3'h0)
    else $error("request with disabled cacheability was counted");

  AST_LEN_SIZE_DIR: assert property (
    sel_mem && i_mem_vld && (!qual_ff[LEN_LSB + 32'(i_mem_len)] ||
    !qual_ff[SIZE_LSB + 32'(i_mem_size)] ||
    !qual_ff[i_mem_wr ? DIR_WR : DIR_RD]) |-> inc == 3'h0)
    else $error("length, size or direction filter ignored");

  AST_MEM_FULL: assert property (
    sel_mem && i_mem_vld && (qual_ff[29:0] == 30'h3FFFFFFF) && en_ff &&
    quiet |=> count_ff == $past(count_ff) + 32'h1)
    else $error("fully enabled memory request not counted");

  AST_CHAN_RANGE: assert property (
    sel_axi && (qual_ff[CHAN_MSB:CHAN_LSB] > CHAN_LAST) |-> !axi_hit)
    else $error("unsupported axi channel counted");

  AST_AXI_ALL: assert property (
    sel_axi && chan_ok && (qual_ff[3:0] == 4'hF) |-> inc == 3'h1)
    else $error("axi cycle with all state bits set not counted");

  AST_AXI_VALID: assert property (
    sel_axi && chan_ok && ch_vld && !qual_ff[AXI_VLD] |-> inc == 3'h0)
    else $error("valid cycle counted while valid bit clear");

  AST_RSP_PORTS: assert property (
    sel_trace && (i_drop_req == 6'h00) && !qual_ff[TR_RSP] &&
    ((i_drop_rsp & untyped_ports) == 6'h00)
    |-> inc == 3'h0)
    else $error("response drop counted while response bit clear");

  AST_REQ_PORTS: assert property (
    sel_trace && (i_drop_rsp == 6'h00) &&
    ((i_drop_req & (TR_REQ_PORTS | untyped_ports)) == 6'h00)
    |-> inc == 3'h0)
    else $error("request drop counted on a port without requests");

  AST_PORT_EN: assert property (
    sel_trace && ((qual_ff[5:0] & (i_drop_rsp | i_drop_req)) == 6'h00)
    |-> inc == 3'h0)
    else $error("drop counted on a disabled trace port");

  AST_NO_EVENT: assert property (
    !sel_mem && !sel_axi && !sel_trace |-> inc == 3'h0)
    else $error("count increment with no countable event selected");

  AST_ACCUM: assert property (
    en_ff && quiet |=> (count_ff == $past(count_ff) + 32'($past(inc))) &&
    (o_count_inc == $past(inc)))
    else $error("counter did not follow the qualified increment");

  AST_AXI_READY: assert property (
    sel_axi && chan_ok && ch_rdy && !qual_ff[AXI_RDY] |-> inc == 3'h0)
    else $error("ready cycle counted while ready bit clear");

  AST_AXI_NREADY: assert property (
    sel_axi && chan_ok && !ch_rdy && !qual_ff[AXI_NRDY] |-> inc == 3'h0)
    else $error("not-ready cycle counted while its bit clear");

  AST_AXI_NVALID: assert property (
    sel_axi && chan_ok && !ch_vld && !qual_ff[AXI_NVLD] |-> inc == 3'h0)
    else $error("not-valid cycle counted while its bit clear");

  AST_PERF_PORT: assert property (
    sel_trace && qual_ff[1] && (i_drop_rsp[1] || i_drop_req[1])
    |-> inc != 3'h0) else $error("perf tracing port drop not counted");

  AST_UNCACHED_RSP: assert property (
    sel_trace && qual_ff[0] && qual_ff[TR_RSP] && i_drop_rsp[0]
    |-> inc != 3'h0) else $error("uncached response drop not counted");

  AST_MEM_IDLE: assert property (
    sel_mem && !i_mem_vld |-> inc == 3'h0)
    else $error("memory event counted with no request issued");

  AST_MEM_BUS: assert property (
    sel_axi_mem |-> bus_idx == 4'h0)
    else $error("memory axi event watches an io unit bus");

  AST_IO_BUS: assert property (
    sel_axi_io |-> (5'(bus_idx) + 5'h07) == evsel_ff)
    else $error("io unit axi event watches the wrong bus");

  AST_TRACE_REQ: assert property (
    sel_trace && (qual_ff[7:0] == 8'h7F) && (i_drop_rsp == 6'h00) &&
    (i_drop_req == 6'h14) |-> inc == 3'h2)
    else $error("request drops on the plain pipe ports miscounted");

  AST_CLEAR_WINS: assert property (
    clr_cnt |=> count_ff == 32'h0 && o_count_inc == 3'h0)
    else $error("event beside a clear was counted");

  AST_DISABLED: assert property (
    !en_ff && quiet |=> count_ff == $past(count_ff) && o_count_inc == 3'h0)
    else $error("counter moved while counting was disabled");

  AST_RESERVED: assert property (
    sel_mem && i_mem_vld && (qual_ff[29:0] == 30'h3FFFFFFF) |-> inc == 3'h1)
    else $error("reserved qualifier bits changed the count");

  COV_MEM_COUNT: cover property (sel_mem && en_ff && mem_hit);
  COV_AXI_IO: cover property (sel_axi_io && en_ff && axi_hit);
  COV_TRACE_MULTI: cover property (sel_trace && en_ff && inc > 3'h1);
  COV_CLEAR: cover property (clr_cnt && inc != 3'h0);
  COV_PERF_PORT: cover property (sel_trace && en_ff && tr_hit[1]);

endmodule : peq_perf_event_qualifier

`default_nettype wire

// >>> peq_pkg.sv
// peq_pkg: constants for the performance event qualifier block
// assumes a 32-bit register port and a single 250 MHz core clock
`default_nettype none

package peq_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the plain register port)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_EVSEL = 8'h00;  // event number select
  localparam logic [7:0] OFS_QUAL = 8'h04;   // qualifier bits
  localparam logic [7:0] OFS_CTRL = 8'h08;   // enable / clear
  localparam logic [7:0] OFS_COUNT = 8'h0C;  // counter value
  localparam logic [4:0] EVSEL_RST = 5'h00;
  localparam logic [31:0] QUAL_RST = 32'hFFFFFFFF;
  localparam int CTRL_EN = 0;                // counting enable
  localparam int CTRL_CLR = 1;               // write 1: clear counter

  // ---------------------------------------------------------------
  // event numbers
  // ---------------------------------------------------------------
  localparam logic [4:0] EV_MEM_REQ = 5'h03;
  localparam logic [4:0] EV_AXI_MEM = 5'h07;
  localparam logic [4:0] EV_AXI_IO_FIRST = 5'h08;
  localparam logic [4:0] EV_AXI_IO_LAST = 5'h0F;
  localparam logic [4:0] EV_TRACE_DROP = 5'h11;

  // ---------------------------------------------------------------
  // qualifier field positions
  // ---------------------------------------------------------------
  localparam int SRC_LSB = 22;   // input ports 7..0 at 29..22
  localparam int CCA_LSB = 18;   // cacheability 21..18
  localparam int LEN_LSB = 10;   // burst length codes 17..10
  localparam int SIZE_LSB = 2;   // bytes per transfer 9..2
  localparam int DIR_WR = 1;
  localparam int DIR_RD = 0;
  localparam int CHAN_MSB = 6;
  localparam int CHAN_LSB = 4;
  localparam int AXI_RDY = 3;
  localparam int AXI_NRDY = 2;
  localparam int AXI_VLD = 1;
  localparam int AXI_NVLD = 0;
  localparam int TR_RSP = 7;
  localparam int TR_REQ = 6;

  // cacheability codes on the request input
  localparam logic [1:0] CCA_PLAIN_UNCACHED = 2'h0;
  localparam logic [1:0] CCA_ACCEL_UNCACHED = 2'h1;
  localparam logic [1:0] CCA_COH_RD_DISCARD = 2'h2;
  localparam logic [1:0] CCA_COH_OTHER = 2'h3;

  // axi channel codes, buses and trace ports
  localparam logic [2:0] CHAN_LAST = 3'h4;   // 0 ar,1 aw,2 w,3 r,4 b
  localparam int NUM_CHAN = 5;
  localparam int NUM_BUS = 9;                // memory bus then 8 io units
  localparam int NUM_TPORT = 6;
  localparam logic [5:0] TR_RSP_PORTS = 6'h3D;  // 5,4,3,2,0
  localparam logic [5:0] TR_REQ_PORTS = 6'h14;  // 4,2

endpackage : peq_pkg

`default_nettype wire

// >>> peq_obs_model.sv
// peq_obs_model: far side of the qualifier, meaning pipelines, axi buses
// and trace ports; the bench calls its tasks from one process on i_clk
`timescale 1ns/10ps
`default_nettype none

module peq_obs_model
  import peq_pkg::*;
(
  input wire logic i_clk, // core clock
  output logic o_mem_vld, // request issued
  output logic [2:0] o_mem_port, // source port
  output logic [1:0] o_mem_cca, // cacheability
  output logic [2:0] o_mem_len, // burst length code
  output logic [2:0] o_mem_size, // log2 bytes per transfer
  output logic o_mem_wr, // direction
  output logic [NUM_BUS*NUM_CHAN-1:0] o_axi_valid, // valid levels
  output logic [NUM_BUS*NUM_CHAN-1:0] o_axi_ready, // ready levels
  output logic [NUM_TPORT-1:0] o_drop_rsp, // response drop pulses
  output logic [NUM_TPORT-1:0] o_drop_req // request drop pulses
);
  // ------------------------------------------------------------
  // idle state and transfer tasks
  // ------------------------------------------------------------
  initial begin
    {o_mem_vld, o_mem_port, o_mem_cca, o_mem_len} = '0;
    {o_mem_size, o_mem_wr, o_axi_valid, o_axi_ready} = '0;
    {o_drop_rsp, o_drop_req} = '0;
  end

  // one request cycle; attributes are not held afterwards, so they are
  // inverted to keep a stale value from passing for a live one
  task automatic mem_req(input logic [2:0] port, input logic [1:0] cca,
                         input logic [2:0] len, input logic [2:0] size,
                         input logic wr);
    @(posedge i_clk);
    o_mem_vld <= 1'b1;
    {o_mem_port, o_mem_cca, o_mem_len} <= {port, cca, len};
    {o_mem_size, o_mem_wr} <= {size, wr};
    @(posedge i_clk);
    o_mem_vld <= 1'b0;
    {o_mem_port, o_mem_cca, o_mem_len} <= ~{port, cca, len};
    {o_mem_size, o_mem_wr} <= ~{size, wr};
  endtask : mem_req

  // axi handshake lines are levels: they stay until the next call
  task automatic axi_cyc(input logic [NUM_BUS*NUM_CHAN-1:0] v,
                         input logic [NUM_BUS*NUM_CHAN-1:0] r);
    @(posedge i_clk);
    o_axi_valid <= v;
    o_axi_ready <= r;
    @(posedge i_clk);
  endtask : axi_cyc

  // one-cycle drop pulses on any set of trace ports
  task automatic drop(input logic [5:0] rsp, input logic [5:0] req);
    @(posedge i_clk);
    o_drop_rsp <= rsp;
    o_drop_req <= req;
    @(posedge i_clk);
    o_drop_rsp <= '0;
    o_drop_req <= '0;
  endtask : drop
endmodule : peq_obs_model

`default_nettype wire

// >>> test_peq_perf_event_qualifier.sv
// test_peq_perf_event_qualifier: self-checking bench for the qualifier
// assumes the design's register map and input encodings from peq_pkg
`timescale 1ns/10ps
`default_nettype none

module test_peq_perf_event_qualifier;
  import peq_pkg::*;
  logic clk, rst_n, wr, rd, mem_vld, mem_wr;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, count;
  logic [2:0] count_inc, mem_port, mem_len, mem_size;
  logic [1:0] mem_cca;
  logic [NUM_BUS*NUM_CHAN-1:0] axi_valid, axi_ready;
  logic [NUM_TPORT-1:0] drop_rsp, drop_req;
  int n_mismatch, cmp_count;

  peq_perf_event_qualifier i_peq_perf_event_qualifier (.i_clk(clk),
    .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_mem_vld(mem_vld),
    .i_mem_port(mem_port), .i_mem_cca(mem_cca), .i_mem_len(mem_len),
    .i_mem_size(mem_size), .i_mem_wr(mem_wr), .i_axi_valid(axi_valid),
    .i_axi_ready(axi_ready), .i_drop_rsp(drop_rsp),
    .i_drop_req(drop_req), .o_count(count), .o_count_inc(count_inc));
  peq_obs_model i_peq_obs_model (.i_clk(clk), .o_mem_vld(mem_vld),
    .o_mem_port(mem_port), .o_mem_cca(mem_cca), .o_mem_len(mem_len),
    .o_mem_size(mem_size), .o_mem_wr(mem_wr), .o_axi_valid(axi_valid),
    .o_axi_ready(axi_ready), .o_drop_rsp(drop_rsp),
    .o_drop_req(drop_req));

  // ------------------------------------------------------------
  // clock, compare and register port tasks
  // ------------------------------------------------------------
  always #2 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                        input string what);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1 check(what, rdata, e);
  endtask : reg_rd

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check("count port", count, 32'h0);
    reg_rd(OFS_EVSEL, 32'h0, "evsel");
    reg_rd(OFS_QUAL, 32'hFFFFFFFF, "qual");
    reg_rd(OFS_CTRL, 32'h0, "ctrl");
    reg_rd(OFS_COUNT, 32'h0, "count");
    reg_rd(8'h10, 32'h0, "unmapped");
    @(posedge clk);
    #1 check("rdata idle", rdata, 32'h0);
  endtask : t_reset

  // walk qualifier bits 29..0: masked alone, then all groups open
  task automatic t_mem();
    logic [2:0] p, l, s;
    logic [1:0] c;
    logic w;
    reg_wr(OFS_EVSEL, 32'h3);
    reg_wr(OFS_CTRL, 32'h1);
    for (int b = 0; b < 30; b++) begin
      {p, c, l, s, w} = {3'h0, 2'h3, 3'h0, 3'h0, 1'b0};
      if (b >= 22) p = 3'(b - 22);
      else if (b >= 18) c = 2'(b - 18);
      else if (b >= 10) l = 3'(b - 10);
      else if (b >= 2) s = 3'(b - 2);
      else w = 1'(b);
      reg_wr(OFS_QUAL, ~(32'h1 << b));
      i_peq_obs_model.mem_req(p, c, l, s, w);
      #1 check("mem masked", 32'(count_inc), 32'h0);
      reg_wr(OFS_QUAL, 32'h3FFFFFFF);
      i_peq_obs_model.mem_req(p, c, l, s, w);
      #1 check("mem passed", 32'(count_inc), 32'h1);
    end
    check("mem total", count, 32'h1E);
  endtask : t_mem

  task automatic t_ctrl();
    reg_wr(OFS_CTRL, 32'h0);
    i_peq_obs_model.mem_req(3'h0, 2'h3, 3'h0, 3'h0, 1'b0);
    #1 check("disabled", 32'(count_inc), 32'h0);
    reg_wr(OFS_COUNT, 32'h0000ABCD);
    reg_rd(OFS_COUNT, 32'h0000ABCD, "count rw");
    reg_wr(OFS_CTRL, 32'h3);
    reg_rd(OFS_COUNT, 32'h0, "cleared");
  endtask : t_ctrl

  // every bus and channel: all others busy while the target is idle
  task automatic t_axi();
    logic [NUM_BUS*NUM_CHAN-1:0] one;
    for (int bus = 0; bus < NUM_BUS; bus++) begin
      for (int ch = 0; ch < NUM_CHAN; ch++) begin
        one = (NUM_BUS*NUM_CHAN)'(1) << (bus * NUM_CHAN + ch);
        reg_wr(OFS_EVSEL, 32'(7 + bus));
        reg_wr(OFS_QUAL, 32'(ch << 4) | 32'hA);
        i_peq_obs_model.axi_cyc(~one, ~one);
        #1 check("axi idle", 32'(count_inc), 32'h0);
        i_peq_obs_model.axi_cyc(one, one);
        #1 check("axi busy", 32'(count_inc), 32'h1);
      end
    end
    for (int q = 0; q < 16; q++) begin
      reg_wr(OFS_QUAL, 32'h40 | 32'(q));
      for (int vr = 0; vr < 4; vr++) begin
        i_peq_obs_model.axi_cyc(vr[0] ? one : '0, vr[1] ? one : '0);
        #1 check("axi level", 32'(count_inc),
                 32'((vr[1] ? q[3] : q[2]) & (vr[0] ? q[1] : q[0])));
      end
    end
    reg_wr(OFS_QUAL, 32'h5F);
    i_peq_obs_model.axi_cyc('1, '1);
    #1 check("axi chan 5", 32'(count_inc), 32'h0);
    i_peq_obs_model.axi_cyc('0, '0);
  endtask : t_axi

  task automatic t_trace();
    logic [5:0] pb;
    reg_wr(OFS_EVSEL, 32'h11);
    for (int p = 0; p < NUM_TPORT; p++) begin
      pb = 6'h1 << p;
      reg_wr(OFS_QUAL, 32'hC0 | 32'(pb));
      i_peq_obs_model.drop(pb, 6'h0);
      #1 check("rsp drop", 32'(count_inc), 32'((6'h3F >> p) & 6'h1));
      i_peq_obs_model.drop(6'h0, pb);
      #1 check("req drop", 32'(count_inc), 32'((6'h16 >> p) & 6'h1));
      i_peq_obs_model.drop(~pb, ~pb);
      #1 check("other port", 32'(count_inc), 32'h0);
    end
    reg_wr(OFS_QUAL, 32'h7F);
    i_peq_obs_model.drop('1, '1);
    #1 check("req only", 32'(count_inc), 32'h3);
    reg_wr(OFS_QUAL, 32'hBF);
    i_peq_obs_model.drop('1, '1);
    #1 check("rsp only", 32'(count_inc), 32'h6);
  endtask : t_trace

  // ------------------------------------------------------------
  // verdict and main sequence
  // ------------------------------------------------------------
  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial begin
    {clk, rst_n, wr, rd, addr, wdata} = '0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_mem();
    t_ctrl();
    t_axi();
    t_trace();
    results();
  end
endmodule : test_peq_perf_event_qualifier

`default_nettype wire
